// ### dcl_bus_mem.sv
// Purpose: memory model on the system bus side of the data cache
// Assumes: one beat per bus_valid, acked by a one-cycle bus_ack
// Notes: read data is address xor a fixed pattern; answer delay alternates
`timescale 1ns/1ps

module dcl_bus_mem (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic bus_valid,
    input wire logic bus_write,
    input wire logic [31:0] bus_addr,
    output logic bus_ack,
    output logic [31:0] bus_rdata
);
    logic [1:0] wait_q;
    logic slow_q;

    // outside an ack the data lines toggle, so stale data never looks valid
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bus_ack <= 1'b0;
            bus_rdata <= 32'h0;
            wait_q <= 2'h0;
            slow_q <= 1'b0;
        end else if (bus_ack) begin
            bus_ack <= 1'b0;
            bus_rdata <= ~bus_rdata;
        end else if (bus_valid && wait_q == 2'h0) begin
            bus_ack <= 1'b1;
            bus_rdata <= bus_write ? ~bus_rdata : (bus_addr ^ 32'hc3a5_5a3c);
            slow_q <= ~slow_q;
            wait_q <= slow_q ? 2'h0 : 2'h3;
        end else begin
            if (bus_valid) begin
                wait_q <= wait_q - 2'h1;
            end
            bus_rdata <= ~bus_rdata;
        end
    end
endmodule // dcl_bus_mem

// ### dcl_data_cache.sv
// Purpose: data cache controller with linefill, writeback and lockdown
// Assumes: core issues one word request at a time; bus answers each beat with bus_ack
// Notes: virtual tags, writeback uses the stored tag as address
//
// Summary of operation
// - enable off skips lookup; Ctt clear blocks allocation and read hits
// - cacheable read miss fills 8-word line
// - victim chosen among unlocked lines, random or round-robin
// - dirty victim written back, 4 or 8 words
// - writeback buffered first, then linefill read
// - uncached multi-word accesses go out sequential
// - sequential bursts never cross 1KB boundary
// - bit 14 selects round-robin, random at reset
// - cacheable swap is load then store, unlocked
// - no interrupt between swap read and write
// - uncached swap drains buffer, then single read
// - uncached swap write unbuffered, core stalls
// - uncached swap asserts bus lock
// - 8 segments of 64 lines of 8 words
// - segment from address bits 7:5
// - bits 4:2 word, 1:0 halfword/byte
// - linefill stores address bits 31:8 as tag
// - hit compares bits 31:8 with stored tags
// - unlocked victim index anywhere 0 to 63
// - base pointer limits victims to base..63
// - lockdown write forces next victim index
// - two dirty flags, one valid, one tag per line
// - write-back store hit sets half dirty
// - reset invalidates, disables, empties write buffer
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps

module dcl_data_cache
    import dcl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_swap,
    input wire logic req_seq,
    input wire logic [1:0] req_size,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] req_wdata,
    input wire logic req_cacheable,
    input wire logic req_bufferable,
    output logic req_ready,
    output logic resp_valid,
    output logic [31:0] resp_rdata,
    output logic irq_block,
    output logic bus_valid,
    output logic bus_write,
    output logic bus_seq,
    output logic bus_lock_indicator,
    output logic [1:0] bus_size,
    output logic [31:0] bus_addr,
    output logic [31:0] bus_wdata,
    input wire logic bus_ack,
    input wire logic [31:0] bus_rdata,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    typedef struct packed {
        dcl_state_t st;
        dcl_state_t nxt;
        logic ccr;
        logic rsel;
        logic force_vic;
        logic [5:0] base;
        logic [5:0] ctr;
        logic [5:0] victim;
        logic [7:0] lfsr;
        logic [31:0] raddr;
        logic [31:0] rwdata;
        logic [1:0] rsize;
        logic rwrite;
        logic rswap;
        logic rseq;
        logic rc;
        logic rb;
        logic [1:0] vdirty;
        logic evict;
        logic [2:0] beat;
        logic [NLINES-1:0] valid;
        logic [NLINES-1:0] dirty0;
        logic [NLINES-1:0] dirty1;
        logic [WQ_DEPTH-1:0][31:0] wq_addr;
        logic [WQ_DEPTH-1:0][31:0] wq_data;
        logic [WQ_DEPTH-1:0][1:0] wq_size;
        logic [WQ_DEPTH-1:0] wq_seq;
        logic [2:0] wq_rd;
        logic [2:0] wq_wr;
        logic [3:0] wq_cnt;
        logic bv;
        logic bsrc;
        logic bwrite;
        logic bseq;
        logic lock;
        logic [1:0] bsize;
        logic [31:0] baddr;
        logic [31:0] bwdata;
        logic rvalid;
        logic [31:0] rdat;
        logic ready;
        logic irqb;
        logic [31:0] regrd;
    } dcl_regs_t;

    dcl_regs_t q;
    dcl_regs_t d;

    logic [23:0] tag_mem [NLINES];
    logic [31:0] data_mem [NDWORDS];

    logic lk_hit;
    logic [5:0] hidx;
    logic [2:0] seg;
    logic [8:0] vline;
    logic [23:0] ev_tag;
    logic [11:0] rd_idx;
    logic [31:0] rd_word;
    logic [31:0] wmask;
    logic [5:0] vsel;
    logic cach;
    logic beat_done;
    logic pop;
    logic push;
    logic [31:0] push_addr;
    logic [31:0] push_data;
    logic [1:0] push_size;
    logic push_seq;
    logic dm_we;
    logic [11:0] dm_idx;
    logic [31:0] dm_wdata;
    logic tm_we;

    assign seg = q.raddr[7:5];
    assign vline = {seg, q.victim};
    assign ev_tag = tag_mem[vline];
    assign cach = q.rc & q.ccr;

    // tag search over the 64 lines of the addressed segment
    always_comb begin
        lk_hit = 1'b0;
        hidx = IDX_RST;
        for (int i = 0; i < NIDX; i++) begin
            if (q.ccr && q.valid[{seg, 6'(i)}] && tag_mem[{seg, 6'(i)}] == q.raddr[31:8]) begin
                lk_hit = 1'b1;
                hidx = 6'(i);
            end
        end
    end

    // word select and lane mask
    assign rd_idx = (q.st == S_EVICT) ? {seg, q.victim, q.beat} : {seg, hidx, q.raddr[4:2]};
    assign rd_word = data_mem[rd_idx];
    always_comb begin
        unique case (q.rsize)
            SZ_WORD: wmask = 32'hffffffff;
            SZ_HALF: wmask = q.raddr[1] ? 32'hffff0000 : 32'h0000ffff;
            default: wmask = 32'h000000ff << {q.raddr[1:0], 3'h0};
        endcase
    end

    // victim among unlocked indices base..63
    always_comb begin
        vsel = (q.lfsr[5:0] >= q.base) ? q.lfsr[5:0] : q.base;
        if (q.rsel || q.force_vic) begin
            vsel = q.ctr;
        end
    end

    assign beat_done = q.bv && bus_ack;
    assign pop = beat_done && !q.bsrc;

    always_comb begin
        d = q;
        d.rvalid = 1'b0;
        d.regrd = 32'h00000000;
        d.lfsr = {q.lfsr[6:0], ~(q.lfsr[7] ^ q.lfsr[5] ^ q.lfsr[4] ^ q.lfsr[3])};
        push = 1'b0;
        push_addr = q.raddr;
        push_data = q.rwdata;
        push_size = q.rsize;
        push_seq = q.rseq;
        dm_we = 1'b0;
        dm_idx = {seg, hidx, q.raddr[4:2]};
        dm_wdata = (rd_word & ~wmask) | (q.rwdata & wmask);
        tm_we = 1'b0;
        if (beat_done) begin
            d.bv = 1'b0;
        end
        if (reg_wr) begin
            case (reg_addr)
                REG_CTRL_OFS: begin
                    d.ccr = reg_wdata[CTRL_CEN_BIT];
                    d.rsel = reg_wdata[CTRL_RSEL_BIT];
                end
                REG_LOCK_OFS: begin
                    d.base = reg_wdata[LOCK_BASE_LSB +: 6];
                    d.ctr = reg_wdata[LOCK_VIC_LSB +: 6];
                    d.force_vic = 1'b1;
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                REG_STAT_OFS: d.regrd = {8'h00, 2'h0, q.base, 2'h0, q.ctr, q.wq_cnt, 1'b0, q.st};
                REG_CTRL_OFS: begin
                    d.regrd[CTRL_CEN_BIT] = q.ccr;
                    d.regrd[CTRL_RSEL_BIT] = q.rsel;
                end
                REG_LOCK_OFS: begin
                    d.regrd[LOCK_BASE_LSB +: 6] = q.base;
                    d.regrd[LOCK_VIC_LSB +: 6] = q.ctr;
                end
                default: ;
            endcase
        end
        unique case (q.st)
            S_IDLE: begin
                if (req_valid) begin
                    d.raddr = req_addr;
                    d.rwdata = req_wdata;
                    d.rsize = req_size;
                    d.rwrite = req_write;
                    d.rswap = req_swap;
                    d.rseq = req_seq;
                    d.rc = req_cacheable;
                    d.rb = req_bufferable;
                    d.lock = 1'b0;
                    d.st = S_LOOK;
                end
            end
            S_LOOK: begin
                if (q.rswap && !cach && !q.lock) begin
                    d.nxt = S_UNC;
                    d.evict = 1'b0;
                    d.st = S_DRAIN;
                end else if (!q.rwrite) begin
                    if (cach && lk_hit) begin
                        d.rdat = rd_word;
                        if (q.rswap) begin
                            d.rwrite = 1'b1;
                        end else begin
                            d.rvalid = 1'b1;
                            d.st = S_IDLE;
                        end
                    end else if (cach) begin
                        d.victim = vsel;
                        d.vdirty = {q.dirty1[{seg, vsel}], q.dirty0[{seg, vsel}]};
                        d.evict = q.valid[{seg, vsel}] &&
                            (q.dirty1[{seg, vsel}] || q.dirty0[{seg, vsel}]);
                        d.nxt = S_FILL;
                        d.beat = 3'h0;
                        d.st = S_DRAIN;
                    end else begin
                        d.nxt = S_UNC;
                        d.evict = 1'b0;
                        d.st = S_DRAIN;
                    end
                end else begin
                    if (lk_hit) begin
                        dm_we = 1'b1;
                        if (cach && q.rb) begin
                            d.dirty0[{seg, hidx}] = q.dirty0[{seg, hidx}] | ~q.raddr[4];
                            d.dirty1[{seg, hidx}] = q.dirty1[{seg, hidx}] | q.raddr[4];
                        end
                    end
                    if (cach && q.rb && lk_hit) begin
                        d.rvalid = 1'b1;
                        d.st = S_IDLE;
                    end else if (!cach && !q.rb) begin
                        d.nxt = S_UNC;
                        d.evict = 1'b0;
                        d.st = S_DRAIN;
                    end else if (q.wq_cnt != WQ_FULL) begin
                        push = 1'b1;
                        d.rvalid = 1'b1;
                        d.st = S_IDLE;
                    end
                end
            end
            S_DRAIN: begin
                if (q.wq_cnt == 4'h0 && !q.bv) begin
                    d.beat = 3'h0;
                    // lock only once older buffered writes have left the bus
                    d.lock = q.rswap && (q.nxt == S_UNC);
                    d.st = q.evict ? S_EVICT : q.nxt;
                end
            end
            S_EVICT: begin
                // buffer is empty on entry, so 8 pushes always fit
                if (q.beat[2] ? q.vdirty[1] : q.vdirty[0]) begin
                    push = 1'b1;
                    push_addr = {ev_tag, seg, q.beat, 2'h0};
                    push_data = rd_word;
                    push_size = SZ_WORD;
                    push_seq = (q.beat[1:0] != 2'h0) || (q.beat == HALF_BEAT && q.vdirty[0]);
                end
                d.beat = q.beat + 3'h1;
                if (q.beat == LAST_BEAT) begin
                    d.st = S_FILL;
                end
            end
            S_FILL: begin
                if (!q.bv) begin
                    d.bv = 1'b1;
                    d.bsrc = 1'b1;
                    d.bwrite = 1'b0;
                    d.bsize = SZ_WORD;
                    d.baddr = {q.raddr[31:5], q.beat, 2'h0};
                    d.bseq = (q.beat != 3'h0) && (q.raddr[9:2] != KB_WORD0 || q.beat != 3'h0);
                end
                if (beat_done && q.bsrc) begin
                    dm_we = 1'b1;
                    dm_idx = {seg, q.victim, q.beat};
                    dm_wdata = bus_rdata;
                    d.beat = q.beat + 3'h1;
                    if (q.beat == LAST_BEAT) begin
                        tm_we = 1'b1;
                        d.valid[vline] = 1'b1;
                        d.dirty0[vline] = 1'b0;
                        d.dirty1[vline] = 1'b0;
                        // a lockdown write in this cycle wins over the advance
                        if (!(reg_wr && reg_addr == REG_LOCK_OFS)) begin
                            d.ctr = (q.ctr == IDX_MAX) ? q.base : q.ctr + 6'h1;
                            d.force_vic = 1'b0;
                        end
                        d.st = S_LOOK;
                    end
                end
            end
            S_UNC: begin
                if (!q.bv && !(beat_done)) begin
                    d.bv = 1'b1;
                    d.bsrc = 1'b1;
                    d.bwrite = q.rwrite;
                    d.bsize = q.rsize;
                    d.baddr = q.raddr;
                    d.bwdata = q.rwdata;
                    d.bseq = q.rseq && !q.rswap && (q.raddr[9:2] != KB_WORD0);
                end
                if (beat_done && q.bsrc) begin
                    if (!q.rwrite) begin
                        d.rdat = bus_rdata;
                    end
                    if (q.rswap && !q.rwrite) begin
                        d.rwrite = 1'b1;
                    end else begin
                        d.lock = 1'b0;
                        d.rvalid = 1'b1;
                        d.st = S_IDLE;
                    end
                end
            end
            default: d.st = S_IDLE;
        endcase
        // drain the write buffer whenever the line engine leaves the bus free
        if (!q.bv && q.wq_cnt != 4'h0 && q.st != S_FILL && q.st != S_UNC) begin
            d.bv = 1'b1;
            d.bsrc = 1'b0;
            d.bwrite = 1'b1;
            d.bsize = q.wq_size[q.wq_rd];
            d.baddr = q.wq_addr[q.wq_rd];
            d.bwdata = q.wq_data[q.wq_rd];
            d.bseq = q.wq_seq[q.wq_rd] && (q.wq_addr[q.wq_rd][9:2] != KB_WORD0);
        end
        if (push) begin
            d.wq_addr[q.wq_wr] = push_addr;
            d.wq_data[q.wq_wr] = push_data;
            d.wq_size[q.wq_wr] = push_size;
            d.wq_seq[q.wq_wr] = push_seq;
            d.wq_wr = q.wq_wr + 3'h1;
        end
        if (pop) begin
            d.wq_rd = q.wq_rd + 3'h1;
        end
        d.wq_cnt = 4'(q.wq_cnt + {3'h0, push} - {3'h0, pop});
        d.ready = (d.st == S_IDLE);
        d.irqb = d.rswap && (d.st != S_IDLE);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // cache storage: 8 segments x 64 lines x 8 words
    always_ff @(posedge ref_clk) begin
        if (dm_we) begin
            data_mem[dm_idx] <= dm_wdata;
        end
        if (tm_we) begin
            tag_mem[vline] <= q.raddr[31:8];
        end
    end

    assign req_ready = q.ready;
    assign resp_valid = q.rvalid;
    assign resp_rdata = q.rdat;
    assign irq_block = q.irqb;
    assign bus_valid = q.bv;
    assign bus_write = q.bwrite;
    assign bus_seq = q.bseq;
    assign bus_lock_indicator = q.lock;
    assign bus_size = q.bsize;
    assign bus_addr = q.baddr;
    assign bus_wdata = q.bwdata;
    assign reg_rdata = q.regrd;

    sequence s_evict_done;
        q.st == S_EVICT && q.beat == LAST_BEAT;
    endsequence

    sequence s_fill_read;
        q.bv && q.bsrc && !q.bwrite;
    endsequence

    chk_lookup_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (q.st == S_LOOK && !q.ccr && !q.rwrite) |-> (!lk_hit ##1 (q.st == S_DRAIN && q.nxt == S_UNC)))
        else $error("lookup with cache disabled");

    chk_fill_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (q.st == S_FILL && beat_done && q.beat == LAST_BEAT) |=> (q.st == S_LOOK && lk_hit))
        else $error("linefill did not install line");

    chk_victim_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (q.st == S_DRAIN && q.nxt == S_FILL && !q.force_vic) |-> q.victim >= q.base)
        else $error("victim below base");

    chk_ctr_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (q.st == S_FILL && beat_done && q.beat == LAST_BEAT && q.ctr == IDX_MAX && !reg_wr)
        |=> q.ctr == $past(q.base)) else $error("counter did not wrap to base");

    chk_no_1k_cross: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (q.bv && q.bseq) |-> q.baddr[9:2] != KB_WORD0) else $error("burst crosses 1KB");

    chk_cached_swap_unlock: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (q.rswap && cach && q.st == S_LOOK) |-> !q.lock) else $error("lock on cached swap");

    chk_swap_write_unbuf: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (q.bv && q.lock && q.bwrite) |-> (q.bsrc && q.wq_cnt == 4'h0))
        else $error("locked swap write went through buffer");

    chk_swap_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ((q.bv && q.lock) || (q.st == S_LOOK && q.rswap && q.rwrite)) |-> q.irqb)
        else $error("interrupt window inside swap");

    chk_evict_then_fill: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_evict_done |=> (q.st == S_FILL) ##[0:300] s_fill_read)
        else $error("linefill did not follow writeback");

    chk_dirty_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (q.st == S_LOOK && q.rwrite && cach && q.rb && lk_hit && !q.raddr[4])
        |=> q.dirty0[{$past(seg), $past(hidx)}]) else $error("dirty flag not set");

endmodule // dcl_data_cache

// ### dcl_data_cache_tb_top.sv
// Purpose: self-checking bench for dcl_data_cache
// Assumes: bus answered by dcl_bus_mem, read data = address xor pattern
// Notes: scenarios run back to back after one reset
`timescale 1ns/1ps

module dcl_data_cache_tb_top
    import dcl_pkg::*;
;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0, req_swap = 1'b0, req_seq = 1'b0;
    logic req_cacheable = 1'b0, req_bufferable = 1'b0;
    logic [1:0] req_size = SZ_WORD;
    logic [31:0] req_addr = 32'h0, req_wdata = 32'h0;
    logic req_ready, resp_valid, irq_block, bus_valid, bus_write, bus_seq, bus_lock_indicator;
    logic [31:0] resp_rdata, bus_addr, bus_wdata, bus_rdata, reg_rdata;
    logic [1:0] bus_size;
    logic bus_ack;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    int fails = 0, n_compared = 0;
    int n_rd = 0, n_wr = 0, n_lock = 0, n_seq = 0, n_irq = 0, wr_at_lock = 0;
    logic [31:0] last_wr = 32'h0;

    always #2 ref_clk = ~ref_clk;

    dcl_data_cache i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_write(req_write), .req_swap(req_swap), .req_seq(req_seq), .req_size(req_size),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_cacheable(req_cacheable),
        .req_bufferable(req_bufferable), .req_ready(req_ready), .resp_valid(resp_valid),
        .resp_rdata(resp_rdata), .irq_block(irq_block), .bus_valid(bus_valid),
        .bus_write(bus_write), .bus_seq(bus_seq), .bus_lock_indicator(bus_lock_indicator),
        .bus_size(bus_size), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
        .bus_rdata(bus_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    dcl_bus_mem i_mem (.ref_clk(ref_clk), .rst_n(rst_n), .bus_valid(bus_valid),
        .bus_write(bus_write), .bus_addr(bus_addr), .bus_ack(bus_ack), .bus_rdata(bus_rdata));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // bus beat monitor
    always @(posedge ref_clk) begin
        if (irq_block === 1'b1) begin
            n_irq <= n_irq + 1;
        end
        if (bus_valid === 1'b1 && bus_ack === 1'b1) begin
            chk("seq_at_1kb", {31'h0, bus_seq & (bus_addr[9:2] == 8'h0)}, 32'h0);
            if (bus_write && bus_addr == 32'h0000_1124) begin
                chk("evict_word", bus_wdata, 32'h1234_5678);
            end
            if (bus_write) begin
                n_wr <= n_wr + 1;
                last_wr <= bus_addr;
            end else begin
                n_rd <= n_rd + 1;
            end
            if (bus_lock_indicator) begin
                n_lock <= n_lock + 1;
            end
            if (bus_lock_indicator && !bus_write) begin
                wr_at_lock <= n_wr;
            end
            if (bus_seq) begin
                n_seq <= n_seq + 1;
            end
        end
    end

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask

    task automatic core(input logic wr, sw, sq, c, b, input logic [31:0] a, wd,
                        output logic [31:0] rd);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_swap <= sw;
        req_seq <= sq;
        req_cacheable <= c;
        req_bufferable <= b;
        req_addr <= a;
        req_wdata <= wd;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (resp_valid !== 1'b1 && n < 400);
        chk("resp_valid", {31'h0, resp_valid}, 32'h1);
        rd = resp_rdata;
    endtask

    function automatic logic [31:0] pat(input logic [31:0] a);
        return a ^ 32'hc3a5_5a3c;
    endfunction

    task automatic t_regs_and_off();
        logic [31:0] d;
        int r0;
        reg_read(REG_CTRL_OFS, d);
        chk("ctrl_reset", d, 32'h0);
        reg_write(8'h40, 32'hffff_ffff);
        reg_read(8'h40, d);
        chk("unmapped", d, 32'h0);
        r0 = n_rd;
        core(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_0804, 32'h0, d);
        chk("off_data", d, pat(32'h0000_0804));
        chk("off_reads", 32'(n_rd - r0), 32'h1);
        reg_write(REG_CTRL_OFS, 32'h0000_4004);
        reg_read(REG_CTRL_OFS, d);
        chk("ctrl_rsel", d, 32'h0000_4004);
    endtask

    task automatic t_fill_and_lock();
        logic [31:0] d;
        int r0;
        reg_write(REG_LOCK_OFS, 32'h1490_0000);
        reg_read(REG_STAT_OFS, d);
        chk("lock_base", {26'h0, d[21:16]}, 32'h5);
        chk("lock_ctr", {26'h0, d[13:8]}, 32'h9);
        r0 = n_rd;
        core(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_1124, 32'h0, d);
        chk("fill_data", d, pat(32'h0000_1124));
        chk("fill_reads", 32'(n_rd - r0), 32'h8);
        reg_read(REG_STAT_OFS, d);
        chk("ctr_next", {26'h0, d[13:8]}, 32'ha);
        r0 = n_rd;
        core(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_1138, 32'h0, d);
        chk("hit_data", d, pat(32'h0000_1138));
        chk("hit_reads", 32'(n_rd - r0), 32'h0);
        reg_write(REG_LOCK_OFS, 32'h17f0_0000);
        core(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_3204, 32'h0, d);
        chk("wrap_data", d, pat(32'h0000_3204));
        reg_read(REG_STAT_OFS, d);
        chk("ctr_wrap", {26'h0, d[13:8]}, 32'h5);
    endtask

    task automatic t_writeback();
        logic [31:0] d;
        int r0, w0, n;
        w0 = n_wr;
        core(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_1124, 32'h1234_5678, d);
        reg_write(REG_LOCK_OFS, 32'h1490_0000);
        r0 = n_rd;
        core(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_2124, 32'h0, d);
        chk("evict_data", d, pat(32'h0000_2124));
        chk("evict_reads", 32'(n_rd - r0), 32'h8);
        n = 0;
        while (n_wr < w0 + 4 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        repeat (20) @(negedge ref_clk);
        chk("evict_writes", 32'(n_wr - w0), 32'h4);
        chk("evict_last", last_wr, 32'h0000_112c);
    endtask

    task automatic t_burst();
        logic [31:0] d;
        int r0, s0;
        // addresses kept clear of cached lines
        r0 = n_rd;
        s0 = n_seq;
        core(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0000_03f8, 32'h0, d);
        core(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 32'h0000_03fc, 32'h0, d);
        core(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 32'h0000_0400, 32'h0, d);
        chk("burst_data", d, pat(32'h0000_0400));
        chk("burst_reads", 32'(n_rd - r0), 32'h3);
        chk("burst_seq", 32'(n_seq - s0), 32'h1);
    endtask

    task automatic t_swaps();
        logic [31:0] d;
        int w0, l0, i0, r0;
        w0 = n_wr;
        l0 = n_lock;
        i0 = n_irq;
        core(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0000_0500, 32'h0000_00aa, d);
        core(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 32'h0000_0504, 32'h0000_0055, d);
        chk("uswap_data", d, pat(32'h0000_0504));
        chk("uswap_wr", 32'(n_wr - w0), 32'h2);
        chk("uswap_lock", 32'(n_lock - l0), 32'h2);
        chk("uswap_drain", 32'(wr_at_lock - w0), 32'h1);
        chk("uswap_irq", {31'h0, n_irq > i0}, 32'h1);
        l0 = n_lock;
        r0 = n_rd;
        core(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 32'h0000_2128, 32'h0000_0077, d);
        chk("cswap_data", d, pat(32'h0000_2128));
        chk("cswap_lock", 32'(n_lock - l0), 32'h0);
        chk("cswap_reads", 32'(n_rd - r0), 32'h0);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_regs_and_off();
        t_fill_and_lock();
        t_writeback();
        t_burst();
        t_swaps();
        tally_and_finish();
    end
endmodule // dcl_data_cache_tb_top

// ### dcl_pkg.sv
// Purpose: shared constants and types for the data cache linefill/lockdown block
// Assumes: single clock, 32-bit words, 8-word lines
// Notes: register offsets are byte addresses on the plain register port
package dcl_pkg;

    // register port map
    localparam logic [7:0] REG_STAT_OFS = 8'h00;
    localparam logic [7:0] REG_CTRL_OFS = 8'h04;
    localparam logic [7:0] REG_LOCK_OFS = 8'h24;

    // field positions
    localparam int CTRL_CEN_BIT = 2;
    localparam int CTRL_RSEL_BIT = 14;
    localparam int LOCK_BASE_LSB = 26;
    localparam int LOCK_VIC_LSB = 20;

    // geometry
    localparam int NSEG = 8;
    localparam int NIDX = 64;
    localparam int NLINES = 512;
    localparam int NDWORDS = 4096;
    localparam logic [5:0] IDX_MAX = 6'h3f;
    localparam logic [2:0] LAST_BEAT = 3'h7;
    localparam logic [2:0] HALF_BEAT = 3'h4;
    localparam logic [7:0] KB_WORD0 = 8'h00;

    // write buffer
    localparam int WQ_DEPTH = 8;
    localparam logic [3:0] WQ_FULL = 4'h8;

    // access sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;

    // reset values
    localparam logic [7:0] LFSR_RST = 8'h00;
    localparam logic [5:0] IDX_RST = 6'h00;

    typedef enum logic [2:0] {
        S_IDLE,
        S_LOOK,
        S_DRAIN,
        S_EVICT,
        S_FILL,
        S_UNC
    } dcl_state_t;

endpackage
